// ### src/iavi_top.sv
// Interrupt controller core: initialization words, request capture and acknowledge vector generation.
// Functional notes
// - 16-bit host: second ack falling sets in-service bit, rising clears pending bit.
// - 16-bit host: auto-END_OF_IRQ_COMMAND clears in-service at second ack end, else END_OF_IRQ_COMMAND command.
// - Request gone before first ack: answer as level 7, vector and cascade.
// - 8-bit host uses three ack pulses; first returns call opcode 0xcd.
// - Spacing 4: second byte is A7..A5, level on D4..D2, D1..D0 zero.
// - Spacing 8: second byte is A7..A6, level on D5..D3, D2..D0 zero.
// - Third ack in 8-bit host returns address bits 15..8 from word two.
// - 16-bit host first ack freezes and resolves; data bus stays floating.
// - 16-bit host master puts slave identity on cascade lines at first ack end.
// - 16-bit vector: type bits 7..3 and level in 2..0; spacing ignored.
// - Write with D4 high and A0 low is always word one, restarting init.
// - Word one clears mask, fixes priority, slave id 7, no special mask, read PENDING_REQUEST_REG.
// - Word one resets edge detection; each input needs a fresh rising edge unless the level trigger flag is set.
// - Without fourth word: unbuffered, no auto-END_OF_IRQ_COMMAND, 8-bit host.
// - Init takes two to four writes; third if not single, fourth if flagged.
// - Operation command words accepted only after initialization completes.
// - Level trigger flag takes requests from levels, bypassing edge detection.
// - Spacing flag one gives spacing 4, zero gives spacing 8.
// - Master: word three marks slave inputs; master gives only first call byte for a level marked as slave.
// - Slave: word three low bits are identity; drives later bytes on cascade match.
// - Buffered: enable pin is output, master/slave bit selects role; else pin selects.
// - Word four selects host type, special fully nested and auto-END_OF_IRQ_COMMAND.
// - Words two to four and mask written with A0 high; word one with A0 low.
// - Read with write is ignored; bus floats unless selected read or ack drives.
`timescale 1ns/100ps
module iavi_top (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic A0,
    input wire logic [7:0] D_IN,
    output logic [7:0] D_OUT,
    output logic D_OE_N,
    input wire logic IRQ_ACK_STROBE_N,
    input wire logic [iavi_pkg::IAVI_LEVELS-1:0] REQUEST_INPUTS,
    output logic IRQ_OUT,
    input wire logic [iavi_pkg::IAVI_LVL_W-1:0] CASCADE_ID_LINES_IN,
    output logic [iavi_pkg::IAVI_LVL_W-1:0] CASCADE_ID_LINES_OUT,
    output logic CASCADE_ID_LINES_OE_N,
    input wire logic SLAVE_PROG_BUFFER_EN_IN,
    output logic SLAVE_PROG_BUFFER_EN_OUT,
    output logic SLAVE_PROG_BUFFER_EN_OE_N
);
    import iavi_pkg::*;

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;
    logic [SX_W-1:0] raw;
    logic [SX_W-1:0] filt;
    logic [SX_W-1:0] filt_prev_q;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    assign raw = {REQUEST_INPUTS, D_IN, CASCADE_ID_LINES_IN, SLAVE_PROG_BUFFER_EN_IN,
                  A0, IRQ_ACK_STROBE_N, WR_N, RD_N, CS_N};

    // A change is accepted only once the second and third stages agree, so a
    // pin sampled mid-transition cannot produce a one-cycle glitch inside.
    for (genvar g = 0; g < SX_W; g++) begin : g_sync
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic f_q;
        always_ff @(posedge CLK or negedge rst_n) begin
            if (!rst_n) begin
                s1_q <= SX_RESET[g];
                s2_q <= SX_RESET[g];
                s3_q <= SX_RESET[g];
                f_q <= SX_RESET[g];
            end else begin
                s1_q <= raw[g];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    f_q <= s3_q;
                end
            end
        end
        assign filt[g] = f_q;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            filt_prev_q <= SX_RESET;
        end else begin
            filt_prev_q <= filt;
        end
    end

    // ------------------------------------------------------------
    // Strobe decoding
    // ------------------------------------------------------------
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic [7:0] din;
    logic [7:0] ir;
    logic [2:0] cas_in;
    logic wr_act;
    logic wr_act_q;
    logic wr_take;
    logic [7:0] wdata_q;
    logic wa0_q;
    logic ack_fall;
    logic ack_rise;

    assign cs_n = filt[SX_CS];
    assign rd_n = filt[SX_RD];
    assign wr_n = filt[SX_WR];
    assign ack_n = filt[SX_ACK];
    assign din = filt[SX_D +: 8];
    assign ir = filt[SX_IR +: IAVI_LEVELS];
    assign cas_in = filt[SX_CAS +: IAVI_LVL_W];
    assign wr_act = ~wr_n & ~cs_n & rd_n;
    assign wr_take = wr_act_q & ~wr_act;
    assign ack_fall = filt_prev_q[SX_ACK] & ~ack_n;
    assign ack_rise = ~filt_prev_q[SX_ACK] & ack_n;

    // Data and A0 are held from the write strobe, so the word is taken at its trailing edge.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_q <= 1'b0;
            wdata_q <= WORD_RESET;
            wa0_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act;
            if (wr_act) begin
                wdata_q <= din;
                wa0_q <= filt[SX_A0];
            end
        end
    end

    logic take_w1;
    logic take_hi;
    logic take_o2;
    logic take_o3;
    iavi_init_t init_q;

    assign take_w1 = wr_take & ~wa0_q & wdata_q[W1_SEL];
    assign take_hi = wr_take & wa0_q;
    assign take_o2 = wr_take & ~wa0_q & ~wdata_q[W1_SEL] & ~wdata_q[O_SEL3] & (init_q == IAVI_READY);
    assign take_o3 = wr_take & ~wa0_q & ~wdata_q[W1_SEL] & wdata_q[O_SEL3] & (init_q == IAVI_READY);

    // ------------------------------------------------------------
    // Initialization sequence
    // ------------------------------------------------------------
    logic [7:0] init_word_one_q;
    logic [7:0] init_word_two_q;
    logic [7:0] init_word_three_q;
    logic [7:0] init_word_four_q;
    logic [7:0] request_mask_reg_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= IAVI_UNINIT;
            init_word_one_q <= WORD_RESET;
            init_word_two_q <= WORD_RESET;
            init_word_three_q <= SLAVE_ID_RESET;
            init_word_four_q <= WORD_RESET;
        end else if (take_w1) begin
            init_q <= IAVI_WANT_W2;
            init_word_one_q <= wdata_q;
            init_word_three_q <= SLAVE_ID_RESET;
            init_word_four_q <= WORD_RESET;
        end else if (take_hi) begin
            case (init_q)
                IAVI_WANT_W2: begin
                    init_word_two_q <= wdata_q;
                    if (!init_word_one_q[W1_SINGLE_DEVICE_FLAG]) begin
                        init_q <= IAVI_WANT_W3;
                    end else if (init_word_one_q[W1_IC4]) begin
                        init_q <= IAVI_WANT_W4;
                    end else begin
                        init_q <= IAVI_READY;
                    end
                end
                IAVI_WANT_W3: begin
                    init_word_three_q <= wdata_q;
                    init_q <= init_word_one_q[W1_IC4] ? IAVI_WANT_W4 : IAVI_READY;
                end
                IAVI_WANT_W4: begin
                    init_word_four_q <= wdata_q;
                    init_q <= IAVI_READY;
                end
                default: begin
                    init_q <= init_q;
                end
            endcase
        end
    end

    // Decoded configuration.
    logic single;
    logic level_trigger_flag;
    logic call_spacing_flag;
    logic host16;
    logic auto_end_of_irq;
    logic buffered;
    logic master;
    logic special_nested_flag;
    logic ready;

    assign single = init_word_one_q[W1_SINGLE_DEVICE_FLAG];
    assign level_trigger_flag = init_word_one_q[W1_LEVEL_TRIGGER_FLAG];
    assign call_spacing_flag = init_word_one_q[W1_ADI];
    assign host16 = init_word_four_q[W4_UPM];
    assign auto_end_of_irq = init_word_four_q[W4_AUTO_END_OF_IRQ];
    assign special_nested_flag = init_word_four_q[W4_SPECIAL_NESTED_FLAG];
    assign buffered = init_word_four_q[W4_BUF];
    assign master = buffered ? init_word_four_q[W4_MS] : filt[SX_SP];
    assign ready = (init_q == IAVI_READY);

    // ------------------------------------------------------------
    // Operation registers: mask, special mask, read target
    // ------------------------------------------------------------
    logic smm_q;
    logic read_isr_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            request_mask_reg_q <= MASK_RESET;
            smm_q <= 1'b0;
            read_isr_q <= 1'b0;
        end else if (take_w1) begin
            request_mask_reg_q <= MASK_RESET;
            smm_q <= 1'b0;
            read_isr_q <= 1'b0;
        end else if (take_hi && ready) begin
            request_mask_reg_q <= wdata_q;
        end else if (take_o3) begin
            if (wdata_q[O3_ESMM]) begin
                smm_q <= wdata_q[O3_SMM];
            end
            if (wdata_q[O3_RR]) begin
                read_isr_q <= wdata_q[O3_RIS];
            end
        end
    end

    // ------------------------------------------------------------
    // Priority resolution, fixed with level 0 highest
    // ------------------------------------------------------------
    function automatic logic [3:0] iavi_first(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = IAVI_LEVELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : iavi_first

    logic [7:0] pending_request_reg_q;
    logic [7:0] in_service_reg_q;
    logic [7:0] allow;
    logic [3:0] isr_top;
    logic [3:0] req_top;

    assign isr_top = iavi_first(in_service_reg_q);

    // In-service levels block equal and lower levels, or only themselves in special mask mode; special fully nested mode
    // lets a master re-enter a level that carries a slave.
    always_comb begin
        allow = '0;
        for (int i = 0; i < IAVI_LEVELS; i++) begin
            if (smm_q) begin
                allow[i] = ~in_service_reg_q[i];
            end else begin
                allow[i] = ~isr_top[3] || (3'(i) < isr_top[2:0]) ||
                           ((3'(i) == isr_top[2:0]) && special_nested_flag && master && init_word_three_q[i]);
            end
        end
    end

    assign req_top = iavi_first(pending_request_reg_q & ~request_mask_reg_q & allow);

    // ------------------------------------------------------------
    // Acknowledge sequencing
    // ------------------------------------------------------------
    logic [1:0] ack_cnt_q;
    logic [2:0] ack_lvl_q;
    logic ack_real_q;
    logic ack_slave_q;
    logic cas_drive_q;
    logic [1:0] ack_last;
    logic cas_match;
    logic first_ok;
    logic rest_ok;
    logic vec_fall;
    logic vec_rise;
    logic last_rise;

    assign ack_last = host16 ? ACK_VECTOR : ACK_THIRD;
    assign cas_match = (cas_in == init_word_three_q[2:0]);
    assign first_ok = single | master;
    assign rest_ok = single | (master & ~ack_slave_q) | (~master & cas_match);
    assign vec_fall = ack_fall & (ack_cnt_q == ACK_VECTOR) & ready;
    assign vec_rise = ack_rise & (ack_cnt_q == ACK_VECTOR) & ready;
    assign last_rise = ack_rise & (ack_cnt_q == ack_last) & ready;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_cnt_q <= ACK_FIRST;
            ack_lvl_q <= SPURIOUS_LEVEL;
            ack_real_q <= 1'b0;
            ack_slave_q <= 1'b0;
            cas_drive_q <= 1'b0;
        end else if (take_w1 || !ready) begin
            ack_cnt_q <= ACK_FIRST;
            cas_drive_q <= 1'b0;
        end else begin
            if (ack_fall && ack_cnt_q == ACK_FIRST) begin
                // Freeze the winner; a vanished request answers as level 7.
                ack_real_q <= req_top[3];
                ack_lvl_q <= req_top[3] ? req_top[2:0] : SPURIOUS_LEVEL;
                ack_slave_q <= ~single & master &
                               init_word_three_q[req_top[3] ? req_top[2:0] : SPURIOUS_LEVEL];
                if (!host16 && !single && master) begin
                    cas_drive_q <= 1'b1;
                end
            end
            if (ack_rise) begin
                if (ack_cnt_q == ACK_FIRST && host16 && !single && master) begin
                    cas_drive_q <= 1'b1;
                end
                if (ack_cnt_q == ack_last) begin
                    ack_cnt_q <= ACK_FIRST;
                    cas_drive_q <= 1'b0;
                end else begin
                    ack_cnt_q <= ack_cnt_q + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    logic [7:0] ir_prev_q;
    logic [7:0] ir_rise;
    logic [7:0] irr_clr;

    assign ir_rise = ir & ~ir_prev_q;
    assign irr_clr = (vec_rise && ack_real_q) ? (8'h01 << ack_lvl_q) : 8'h00;

    // A fresh edge in the same cycle as the acknowledge clear survives.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ir_prev_q <= 8'hff;
            pending_request_reg_q <= 8'h00;
        end else if (take_w1) begin
            ir_prev_q <= 8'hff;
            pending_request_reg_q <= 8'h00;
        end else begin
            ir_prev_q <= ir;
            if (level_trigger_flag) begin
                pending_request_reg_q <= ir & ~irr_clr;
            end else begin
                pending_request_reg_q <= ((pending_request_reg_q & ir) & ~irr_clr) | ir_rise;
            end
        end
    end

    // ------------------------------------------------------------
    // In-service register
    // ------------------------------------------------------------
    logic [7:0] isr_clr;
    logic isr_set_ok;

    assign isr_set_ok = ack_real_q & (single | master | cas_match);

    always_comb begin
        isr_clr = 8'h00;
        if (take_o2 && wdata_q[O2_EOI]) begin
            if (wdata_q[O2_SL]) begin
                isr_clr = 8'h01 << wdata_q[2:0];
            end else if (isr_top[3]) begin
                isr_clr = 8'h01 << isr_top[2:0];
            end
        end
        if (last_rise && auto_end_of_irq) begin
            isr_clr = isr_clr | (8'h01 << ack_lvl_q);
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            in_service_reg_q <= 8'h00;
        end else if (take_w1) begin
            in_service_reg_q <= 8'h00;
        end else if (vec_fall && isr_set_ok) begin
            in_service_reg_q <= (in_service_reg_q & ~isr_clr) | (8'h01 << ack_lvl_q);
        end else begin
            in_service_reg_q <= in_service_reg_q & ~isr_clr;
        end
    end

    // ------------------------------------------------------------
    // Data bus, cascade and enable pins
    // ------------------------------------------------------------
    logic [7:0] dout_d;
    logic drive_d;
    logic [7:0] low_byte;

    assign low_byte = call_spacing_flag ? {init_word_one_q[7:5], ack_lvl_q, 2'b00}
                          : {init_word_one_q[7:6], ack_lvl_q, 3'b000};

    always_comb begin
        dout_d = 8'h00;
        drive_d = 1'b0;
        if (!ack_n && ready) begin
            if (host16) begin
                if (ack_cnt_q == ACK_VECTOR && rest_ok) begin
                    dout_d = {init_word_two_q[7:3], ack_lvl_q};
                    drive_d = 1'b1;
                end
            end else if (ack_cnt_q == ACK_FIRST && first_ok) begin
                dout_d = CALL_OPCODE;
                drive_d = 1'b1;
            end else if (ack_cnt_q == ACK_VECTOR && rest_ok) begin
                dout_d = low_byte;
                drive_d = 1'b1;
            end else if (ack_cnt_q == ACK_THIRD && rest_ok) begin
                dout_d = init_word_two_q;
                drive_d = 1'b1;
            end
        end else if (!rd_n && !cs_n && wr_n) begin
            dout_d = filt[SX_A0] ? request_mask_reg_q
                                 : (read_isr_q ? in_service_reg_q : pending_request_reg_q);
            drive_d = 1'b1;
        end
    end

    // The enable pin in buffered mode steers an external transceiver, so it
    // follows the data enable in the same cycle.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            D_OUT <= 8'h00;
            D_OE_N <= 1'b1;
            SLAVE_PROG_BUFFER_EN_OUT <= 1'b1;
            SLAVE_PROG_BUFFER_EN_OE_N <= 1'b1;
        end else begin
            D_OUT <= dout_d;
            D_OE_N <= ~drive_d;
            SLAVE_PROG_BUFFER_EN_OUT <= ~drive_d;
            SLAVE_PROG_BUFFER_EN_OE_N <= ~buffered;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CASCADE_ID_LINES_OUT <= 3'h0;
            CASCADE_ID_LINES_OE_N <= 1'b1;
            IRQ_OUT <= 1'b0;
        end else begin
            CASCADE_ID_LINES_OUT <= ack_lvl_q;
            CASCADE_ID_LINES_OE_N <= ~(cas_drive_q & ack_slave_q & master & ~single);
            IRQ_OUT <= req_top[3] & ready & (ack_cnt_q == ACK_FIRST);
        end
    end

endmodule : iavi_top

// ### src/iavi_pkg.sv
// Shared constants and types for the interrupt acknowledge vector and initialization block.
package iavi_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int IAVI_LEVELS = 8;
    localparam int IAVI_LVL_W = 3;

    // ------------------------------------------------------------
    // Bit positions in the synchronised input vector
    // ------------------------------------------------------------
    localparam int SX_CS = 0;
    localparam int SX_RD = 1;
    localparam int SX_WR = 2;
    localparam int SX_ACK = 3;
    localparam int SX_A0 = 4;
    localparam int SX_SP = 5;
    localparam int SX_CAS = 6;
    localparam int SX_D = 9;
    localparam int SX_IR = 17;
    localparam int SX_W = 25;
    localparam logic [SX_W-1:0] SX_RESET = 25'h000000f;

    // ------------------------------------------------------------
    // Field positions of the command words
    // ------------------------------------------------------------
    localparam int W1_IC4 = 0;
    localparam int W1_SINGLE_DEVICE_FLAG = 1;
    localparam int W1_ADI = 2;
    localparam int W1_LEVEL_TRIGGER_FLAG = 3;
    localparam int W1_SEL = 4;
    localparam int W4_UPM = 0;
    localparam int W4_AUTO_END_OF_IRQ = 1;
    localparam int W4_MS = 2;
    localparam int W4_BUF = 3;
    localparam int W4_SPECIAL_NESTED_FLAG = 4;
    localparam int O_SEL3 = 3;
    localparam int O2_EOI = 5;
    localparam int O2_SL = 6;
    localparam int O3_RIS = 0;
    localparam int O3_RR = 1;
    localparam int O3_SMM = 5;
    localparam int O3_ESMM = 6;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [7:0] CALL_OPCODE = 8'hcd;
    localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
    localparam logic [7:0] SLAVE_ID_RESET = 8'h07;
    localparam logic [7:0] WORD_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [1:0] ACK_FIRST = 2'h0;
    localparam logic [1:0] ACK_VECTOR = 2'h1;
    localparam logic [1:0] ACK_THIRD = 2'h2;

    typedef enum logic [2:0] {
        IAVI_UNINIT,
        IAVI_WANT_W2,
        IAVI_WANT_W3,
        IAVI_WANT_W4,
        IAVI_READY
    } iavi_init_t;

endpackage : iavi_pkg

// ### tb/iavi_top_chk.sv
// Port-level assertions for the acknowledge and initialization block.
`timescale 1ns/100ps
module iavi_top_chk (
    input logic CLK,
    input logic RESETN,
    input logic CS_N,
    input logic RD_N,
    input logic WR_N,
    input logic IRQ_ACK_STROBE_N,
    input logic [7:0] D_OUT,
    input logic D_OE_N,
    input logic [2:0] CASCADE_ID_LINES_OUT,
    input logic CASCADE_ID_LINES_OE_N,
    input logic SLAVE_PROG_BUFFER_EN_IN,
    input logic SLAVE_PROG_BUFFER_EN_OE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    bus_float_a: assert property ((CS_N && IRQ_ACK_STROBE_N)[*8] |-> D_OE_N)
        else $error("bus driven while idle");
    drive_cause_a: assert property ($fell(D_OE_N) |-> !$past(IRQ_ACK_STROBE_N, 3) || !$past(RD_N, 3))
        else $error("bus driven without cause");
    read_drive_a: assert property ((!CS_N && !RD_N && WR_N)[*6] |-> !D_OE_N)
        else $error("read not driven");
    write_quiet_a: assert property ((!WR_N && RD_N && IRQ_ACK_STROBE_N)[*8] |-> D_OE_N)
        else $error("bus driven during write");
    ack_release_a: assert property ($rose(IRQ_ACK_STROBE_N) && RD_N |-> ##[1:8] D_OE_N)
        else $error("bus held after ack");
    byte_hold_a: assert property (!D_OE_N && $past(!D_OE_N) && !IRQ_ACK_STROBE_N |-> $stable(D_OUT))
        else $error("vector byte changed");
    cas_hold_a: assert property (!CASCADE_ID_LINES_OE_N && $past(!CASCADE_ID_LINES_OE_N)
        |-> $stable(CASCADE_ID_LINES_OUT))
        else $error("cascade code changed");
    cas_role_a: assert property ((SLAVE_PROG_BUFFER_EN_OE_N && !SLAVE_PROG_BUFFER_EN_IN)[*8]
        |-> CASCADE_ID_LINES_OE_N)
        else $error("slave drove cascade");
endmodule : iavi_top_chk

bind iavi_top iavi_top_chk u_chk (.CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
    .IRQ_ACK_STROBE_N(IRQ_ACK_STROBE_N), .D_OUT(D_OUT), .D_OE_N(D_OE_N),
    .CASCADE_ID_LINES_OUT(CASCADE_ID_LINES_OUT), .CASCADE_ID_LINES_OE_N(CASCADE_ID_LINES_OE_N),
    .SLAVE_PROG_BUFFER_EN_IN(SLAVE_PROG_BUFFER_EN_IN), .SLAVE_PROG_BUFFER_EN_OE_N(SLAVE_PROG_BUFFER_EN_OE_N));

// ### tb/iavi_host_model.sv
// Host processor model: register writes, status reads and acknowledge pulses.
`timescale 1ns/100ps
module iavi_host_model (
    input logic clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic a0,
    output logic [7:0] d_in,
    output logic ack_n,
    input logic [7:0] d_out,
    input logic d_oe_n
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        ack_n = 1'b1;
        a0 = 1'b0;
        d_in = 8'h5a;
    end
    task automatic wr(input logic adr, input logic [7:0] d);
        @(negedge clk);
        a0 = adr;
        d_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (6) @(negedge clk);
        wr_n = 1'b1;
        cs_n = 1'b1;
        repeat (2) @(negedge clk);
        // A released bus must not keep showing the last byte.
        d_in = ~d;
        repeat (6) @(negedge clk);
    endtask : wr
    task automatic rd(input logic adr, output logic [7:0] d, output logic oe);
        @(negedge clk);
        a0 = adr;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (7) @(negedge clk);
        d = d_out;
        oe = d_oe_n;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (7) @(negedge clk);
    endtask : rd
    task automatic ack_lo(output logic [7:0] d, output logic oe);
        @(negedge clk);
        ack_n = 1'b0;
        repeat (7) @(negedge clk);
        d = d_out;
        oe = d_oe_n;
    endtask : ack_lo
    task automatic ack_hi();
        ack_n = 1'b1;
        repeat (7) @(negedge clk);
    endtask : ack_hi
endmodule : iavi_host_model

// ### tb/irq_ack_vector_and_init_test.sv
// Self-checking bench: initialization sequences and acknowledge vectors.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module irq_ack_vector_and_init_test;
    logic clk, resetn, cs_n, rd_n, wr_n, a0, ack_n, roe, oe_n, irq, cas_oe_n, sp_in, sp_out, sp_oe_n;
    logic [7:0] d_in, d_out, req, rdat;
    logic [2:0] cas, cas_in;
    int err_total;
    int total_checks;
    iavi_top dut (.CLK(clk), .RESETN(resetn), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .A0(a0), .D_IN(d_in),
        .D_OUT(d_out), .D_OE_N(oe_n), .IRQ_ACK_STROBE_N(ack_n), .REQUEST_INPUTS(req), .IRQ_OUT(irq),
        .CASCADE_ID_LINES_IN(cas_in), .CASCADE_ID_LINES_OUT(cas), .CASCADE_ID_LINES_OE_N(cas_oe_n),
        .SLAVE_PROG_BUFFER_EN_IN(sp_in), .SLAVE_PROG_BUFFER_EN_OUT(sp_out), .SLAVE_PROG_BUFFER_EN_OE_N(sp_oe_n));
    iavi_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .d_in(d_in),
        .ack_n(ack_n), .d_out(d_out), .d_oe_n(oe_n));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic rdm(input logic ad, input logic [7:0] e);
        host.rd(ad, rdat, roe);
        `CHK({roe, rdat}, {1'b0, e})
    endtask : rdm
    // Raises requests, waits for the interrupt, then runs n acknowledge pulses.
    task automatic seq(input logic [7:0] r, input logic drop, input int n, input logic [23:0] exp,
        input logic [2:0] drv, input logic cas_chk);
        int i;
        req = r;
        i = 0;
        while (irq !== 1'b1) begin
            @(negedge clk);
            i++;
            if (i > 60) begin
                err_total++;
                final_report();
            end
        end
        if (drop) begin
            req = 8'h00;
            repeat (10) @(negedge clk);
        end
        for (i = 0; i < n; i++) begin
            host.ack_lo(rdat, roe);
            `CHK({roe, sp_out}, {2{!drv[i]}})
            if (drv[i]) `CHK(rdat, exp[8*i +: 8])
            if (cas_chk && i == 0) `CHK({cas_oe_n, cas}, 4'h3)
            host.ack_hi();
        end
        req = 8'h00;
        repeat (6) @(negedge clk);
    endtask : seq
    initial begin
        resetn = 1'b0;
        req = 8'h00;
        sp_in = 1'b1;
        cas_in = 3'h0;
        err_total = 0;
        total_checks = 0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        host.wr(1'b0, 8'hb4);
        host.wr(1'b1, 8'h12);
        host.wr(1'b1, 8'h08);
        seq(8'h08, 1'b0, 3, 24'h0000cd, 3'h1, 1'b1);
        host.wr(1'b1, 8'hff);
        rdm(1'b1, 8'hff);
        $display("test cascade master done");
        host.wr(1'b0, 8'hb6);
        host.wr(1'b1, 8'h12);
        rdm(1'b1, 8'h00);
        seq(8'h08, 1'b0, 3, 24'h12accd, 3'h7, 1'b0);
        $display("test spacing four done");
        req = 8'h20;
        host.wr(1'b0, 8'h52);
        host.wr(1'b1, 8'h34);
        repeat (40) @(negedge clk);
        `CHK(irq, 1'b0)
        req = 8'h00;
        repeat (10) @(negedge clk);
        seq(8'h20, 1'b0, 3, 24'h3468cd, 3'h7, 1'b0);
        $display("test spacing eight done");
        host.wr(1'b0, 8'h13);
        host.wr(1'b1, 8'h48);
        host.wr(1'b1, 8'h01);
        seq(8'h04, 1'b1, 2, 24'h004f00, 3'h2, 1'b0);
        seq(8'h20, 1'b0, 2, 24'h004d00, 3'h2, 1'b0);
        host.wr(1'b0, 8'h0b);
        rdm(1'b0, 8'h20);
        $display("test wide host done");
        host.wr(1'b0, 8'h13);
        host.wr(1'b1, 8'h48);
        host.wr(1'b1, 8'h0f);
        `CHK(sp_oe_n, 1'b0)
        seq(8'h20, 1'b0, 2, 24'h004d00, 3'h2, 1'b0);
        host.wr(1'b0, 8'h0b);
        rdm(1'b0, 8'h00);
        $display("test auto end done");
        req = 8'h02;
        host.wr(1'b0, 8'h1a);
        host.wr(1'b1, 8'h34);
        `CHK(sp_oe_n, 1'b1)
        seq(8'h02, 1'b0, 3, 24'h3408cd, 3'h7, 1'b0);
        $display("test level done");
        sp_in = 1'b0;
        cas_in = 3'h5;
        host.wr(1'b0, 8'hb4);
        host.wr(1'b1, 8'h12);
        host.wr(1'b1, 8'h05);
        seq(8'h08, 1'b0, 3, 24'h12ac00, 3'h6, 1'b0);
        $display("test slave done");
        final_report();
    end
endmodule : irq_ack_vector_and_init_test
